/* File: rtl/sto_defines.svh */
// constants for the safe torque off sequencer
// What this block does
// - both shut-off inputs low: enter power-removed state, gate drive off
// - removed, no-alarm mode: flag on, ready/brake off, led blinks green
// - entry completes within 15 ms after both inputs go low
// - input low pulses of 1 ms or less are ignored
// - both inputs high: leave power removal, unexcited until clear
// - one input high alone never releases power removal
// - clear with excitation command: run, ready and brake on, led steady
// - off monitor high only while both inputs are low
// - exactly one input low: monitor low, motor unexcited
// - input a low kills upper arm drive, input b low kills lower arm
// - clear acts on rising edge (1, default) or level (2)
// - clear ignored for a programmable 0 to 100 ms after release
`ifndef STO_DEFINES_SVH
`define STO_DEFINES_SVH
`define STO_CLK_HZ          20000000
`define STO_FILTER_US       1000
`define STO_ENTRY_US        15000
`define STO_BLOCK_MAX_MS    100
`define STO_FILTER_CYC      ((`STO_CLK_HZ / 1000000) * `STO_FILTER_US)
`define STO_CYC_PER_MS      (`STO_CLK_HZ / 1000)
`define STO_LED_HALF_CYC    (`STO_CYC_PER_MS * 250)
`define STO_REG_CTRL        12'h000
`define STO_REG_STATUS      12'h004
`define STO_REG_IRQ_STAT    12'h008
`define STO_REG_IRQ_MASK    12'h00C
`define STO_CLR_EDGE        2'h1
`define STO_CLR_LEVEL       2'h2
`endif

/* File: rtl/sto_pkg.sv */
// types for the safe torque off sequencer
package sto_pkg;
  typedef enum logic [1:0] {
    STO_RUN     = 2'h0,
    STO_REMOVED = 2'h1,
    STO_WAIT    = 2'h3
  } sto_state_t;
endpackage

/* File: rtl/sto_sequencer.sv */
// safe torque off sequencer with apb register access
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "sto_defines.svh"
module sto_sequencer #(
  parameter int FILTER_CYC = `STO_FILTER_CYC,
  parameter int CYC_PER_MS = `STO_CYC_PER_MS,
  parameter int LED_HALF   = `STO_LED_HALF_CYC
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // safety pins and drive requests
  input  wire logic        shutoff_in_a,
  input  wire logic        shutoff_in_b,
  input  wire logic        torque_off_clear,
  input  wire logic        excite_cmd_in,
  // drive status outputs
  output logic             off_monitor_out,
  output logic             torque_off_flag_out,
  output logic             drive_cmd_ready_out,
  output logic             ready_out,
  output logic             brake_release_out,
  output logic             power_alarm_led_out,
  output logic             gate_upper_en_out,
  output logic             gate_lower_en_out,
  output logic             excite_out,
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, two flops each; reset reads every pin as off
  // so that a release always needs fresh evidence from the pins
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {torque_off_clear, shutoff_in_b, shutoff_in_a};
      sync2 <= sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse filter per channel: a low must outlast the filter time
  // off is claimed only after a full filtered low, never straight from reset,
  // so the monitor shows no false pulse when reset is released
  logic [1:0] chan_on;
  logic [1:0] chan_off;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      logic [15:0] low_cnt;
      always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          low_cnt     <= 16'h0000;
          chan_on[g]  <= 1'b0;
          chan_off[g] <= 1'b0;
        end else if (sync2[g]) begin
          low_cnt     <= 16'h0000;
          chan_on[g]  <= 1'b1;
          chan_off[g] <= 1'b0;
        end else if (low_cnt >= 16'(FILTER_CYC)) begin
          chan_on[g]  <= 1'b0;
          chan_off[g] <= 1'b1;
        end else begin
          low_cnt <= low_cnt + 16'h0001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] clr_mode;
  logic [6:0] block_ms;
  logic       alarm_mode;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] ev;
  sto_pkg::sto_state_t state;

  wire rd_stat = psel_in && penable_in && !pwrite_in
                 && paddr_in == `STO_REG_IRQ_STAT;
  wire wr_en   = psel_in && penable_in && pwrite_in;

  // writable configuration
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clr_mode   <= `STO_CLR_EDGE;
      block_ms   <= 7'h00;
      alarm_mode <= 1'b0;
      irq_mask   <= 3'h0;
    end else if (wr_en) begin
      if (paddr_in == `STO_REG_CTRL) begin
        if (pwdata_in[1:0] == `STO_CLR_EDGE
            || pwdata_in[1:0] == `STO_CLR_LEVEL)
          clr_mode <= pwdata_in[1:0];
        if (pwdata_in[14:8] <= 7'(`STO_BLOCK_MAX_MS))
          block_ms <= pwdata_in[14:8];
        alarm_mode <= pwdata_in[16];
      end else if (paddr_in == `STO_REG_IRQ_MASK) begin
        irq_mask <= pwdata_in[2:0];
      end
    end
  end

  // read mux, zero-wait answer
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= 1'b0;
      if (psel_in && !penable_in) begin
        prdata_out <= 32'h0000_0000;
        if (paddr_in == `STO_REG_CTRL)
          prdata_out <= {15'h0, alarm_mode, 1'b0, block_ms, 6'h0, clr_mode};
        else if (paddr_in == `STO_REG_STATUS)
          prdata_out <= {24'h0, state, excite_out, off_monitor_out,
                         chan_on, sync2[1:0]};
        else if (paddr_in == `STO_REG_IRQ_STAT)
          // an event of the setup cycle is shown now, as the access clears
          prdata_out <= {29'h0, irq_stat | ev};
        else if (paddr_in == `STO_REG_IRQ_MASK)
          prdata_out <= {29'h0, irq_mask};
        else
          pslverr_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  wire both_off = chan_off[0] && chan_off[1];
  wire both_on  = chan_on[0] && chan_on[1];
  wire one_off  = chan_on[0] != chan_on[1];
  logic        clr_prev;
  logic [16:0] blk_cyc;
  logic [6:0]  blk_ms_cnt;
  wire blk_done = blk_ms_cnt >= block_ms;
  wire clr_hit  = (clr_mode == `STO_CLR_LEVEL) ? sync2[2]
                                                : (sync2[2] && !clr_prev);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clr_prev <= 1'b1;
    end else begin
      clr_prev <= sync2[2];
    end
  end

  // power state; reset assumes power removed until released
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= sto_pkg::STO_REMOVED;
    end else begin
      case (state)
        sto_pkg::STO_RUN: begin
          if (both_off) state <= sto_pkg::STO_REMOVED;
        end
        sto_pkg::STO_REMOVED: begin
          if (both_on) state <= sto_pkg::STO_WAIT;
        end
        sto_pkg::STO_WAIT: begin
          if (both_off) state <= sto_pkg::STO_REMOVED;
          else if (both_on && blk_done && clr_hit && excite_cmd_in)
            state <= sto_pkg::STO_RUN;
        end
        default: state <= sto_pkg::STO_REMOVED;
      endcase
    end
  end

  // blocking timer after release, counted in ms
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      blk_cyc    <= 17'h00000;
      blk_ms_cnt <= 7'h00;
    end else if (state != sto_pkg::STO_WAIT) begin
      blk_cyc    <= 17'h00000;
      blk_ms_cnt <= 7'h00;
    end else if (!blk_done) begin
      if (blk_cyc >= 17'(CYC_PER_MS - 1)) begin
        blk_cyc    <= 17'h00000;
        blk_ms_cnt <= blk_ms_cnt + 7'h01;
      end else begin
        blk_cyc <= blk_cyc + 17'h00001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // led blink timer
  logic [23:0] led_cnt;
  logic        blink;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      led_cnt <= 24'h000000;
      blink   <= 1'b0;
    end else if (led_cnt >= 24'(LED_HALF - 1)) begin
      led_cnt <= 24'h000000;
      blink   <= !blink;
    end else begin
      led_cnt <= led_cnt + 24'h000001;
    end
  end

  // outputs
  wire run = state == sto_pkg::STO_RUN && !one_off;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      off_monitor_out     <= 1'b0;
      torque_off_flag_out <= 1'b0;
      drive_cmd_ready_out <= 1'b0;
      ready_out           <= 1'b0;
      brake_release_out   <= 1'b0;
      power_alarm_led_out <= 1'b0;
      gate_upper_en_out   <= 1'b0;
      gate_lower_en_out   <= 1'b0;
      excite_out          <= 1'b0;
    end else begin
      off_monitor_out     <= both_off;
      gate_upper_en_out   <= chan_on[0] && run;
      gate_lower_en_out   <= chan_on[1] && run;
      excite_out          <= run;
      torque_off_flag_out <= !alarm_mode && state != sto_pkg::STO_RUN;
      drive_cmd_ready_out <= run;
      ready_out           <= run;
      brake_release_out   <= run;
      power_alarm_led_out <= run ? 1'b1 : blink;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: 0 entry, 1 release, 2 channel mismatch; read clears
  logic       one_off_d;
  sto_pkg::sto_state_t state_d;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_d   <= sto_pkg::STO_REMOVED;
      one_off_d <= 1'b0;
    end else begin
      state_d   <= state;
      one_off_d <= one_off;
    end
  end
  assign ev = {one_off && !one_off_d,
               state == sto_pkg::STO_WAIT && state_d == sto_pkg::STO_REMOVED,
               state == sto_pkg::STO_REMOVED
               && state_d != sto_pkg::STO_REMOVED};

  // set wins over read clear
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat <= 3'h0;
      irq_out  <= 1'b0;
    end else begin
      irq_stat <= (rd_stat ? 3'h0 : irq_stat) | ev;
      irq_out  <= |(((rd_stat ? 3'h0 : irq_stat) | ev) & irq_mask);
    end
  end

endmodule

/* File: tb/sto_asserts.sv */
// checker for the safe torque off sequencer pins
`timescale 1ns/1ns
module sto_asserts #(
  parameter int FILTER_CYC = 20,
  parameter int CYC_PER_MS = 20
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // watched pins
  input wire logic shutoff_in_a,
  input wire logic shutoff_in_b,
  input wire logic excite_cmd_in,
  input wire logic off_monitor_out,
  input wire logic torque_off_flag_out,
  input wire logic drive_cmd_ready_out,
  input wire logic ready_out,
  input wire logic brake_release_out,
  input wire logic power_alarm_led_out,
  input wire logic gate_upper_en_out,
  input wire logic gate_lower_en_out,
  input wire logic excite_out
);
  localparam int ENTRY = 15 * CYC_PER_MS;
  int lo_a;
  int lo_b;
  int lo_ab;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // raw low time of each channel, saturating
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lo_a <= 0;
      lo_b <= 0;
    end else begin
      lo_a <= shutoff_in_a ? 0 : lo_a + int'(lo_a < 9999);
      lo_b <= shutoff_in_b ? 0 : lo_b + int'(lo_b < 9999);
    end
  end
  // time both channels have been low together
  assign lo_ab = (lo_a < lo_b) ? lo_a : lo_b;
  ////////////////////////////////////////////////////////////////////////
  AST_MON_ON: assert property (
    (shutoff_in_a || shutoff_in_b) [*6] |-> !off_monitor_out)
    else $error("monitor high while a channel is on");
  AST_MON_FILT: assert property (
    $rose(off_monitor_out) |-> lo_ab >= FILTER_CYC)
    else $error("monitor rose on a short low pulse");
  AST_ENTRY: assert property (
    lo_ab == ENTRY |-> off_monitor_out && !gate_upper_en_out
      && !gate_lower_en_out)
    else $error("power removal late");
  AST_REM_OUT: assert property (
    off_monitor_out [*3] |-> torque_off_flag_out && !ready_out
      && !drive_cmd_ready_out && !brake_release_out)
    else $error("status outputs wrong while removed");
  AST_GATE_A: assert property (
    lo_a > FILTER_CYC + 4 |-> !gate_upper_en_out)
    else $error("upper arm driven with channel a off");
  AST_GATE_B: assert property (
    lo_b > FILTER_CYC + 4 |-> !gate_lower_en_out)
    else $error("lower arm driven with channel b off");
  AST_RUN_OUT: assert property (
    excite_out |-> ready_out && drive_cmd_ready_out && brake_release_out
      && !torque_off_flag_out && power_alarm_led_out)
    else $error("status outputs wrong while running");
  AST_RUN_CMD: assert property (
    $rose(excite_out) |-> $past(excite_cmd_in, 2) && !off_monitor_out)
    else $error("excited without command");
  // main scenarios reached
  COV_ENTRY: cover property ($rose(off_monitor_out));
  COV_RUN: cover property ($rose(excite_out));
  COV_ONE_OFF: cover property ($fell(gate_lower_en_out));
endmodule

/* File: tb/sto_safety_model.sv */
// model of the external safety module driving both channels
`timescale 1ns/1ns
module sto_safety_model (
  // clock, commands from the bench and off monitor feedback from the sequencer
  input  wire logic clk_sys_in,
  input  wire logic door_open_in,
  input  wire logic pulse_a_in,
  input  wire logic stuck_b_in,
  input  wire logic feedback_in,
  // safety outputs
  output logic      shutoff_in_a,
  output logic      shutoff_in_b
);
  logic out_on = 1'b1;
  // outputs drop with the door and re-arm only on monitor feedback
  always @(posedge clk_sys_in) begin
    if (door_open_in)
      out_on <= 1'b0;
    else if (feedback_in)
      out_on <= 1'b1;
  end
  // self-test pulse on a, wiring fault holding b low
  assign shutoff_in_a = out_on & ~pulse_a_in;
  assign shutoff_in_b = out_on & ~stuck_b_in;
endmodule

/* File: tb/sto_sequencer_tb_top.sv */
// bench for the safe torque off sequencer
`timescale 1ns/1ns
module sto_sequencer_tb_top;
  localparam int M = 20;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, psel_in = 1'b0;
  logic penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic shutoff_in_a, shutoff_in_b, torque_off_clear = 1'b0;
  logic excite_cmd_in = 1'b0, door_open = 1'b0, pulse_a = 1'b0;
  logic stuck_b = 1'b0, off_monitor_out, torque_off_flag_out, irq_out;
  logic drive_cmd_ready_out, ready_out, brake_release_out, excite_out;
  logic power_alarm_led_out, gate_upper_en_out, gate_lower_en_out;
  int failures = 0, num_checks = 0, cyc = 0;
  // clock
  always #25 clk_sys_in = ~clk_sys_in;
  sto_sequencer #(.FILTER_CYC(M), .CYC_PER_MS(M), .LED_HALF(8))
    sto_sequencer_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .shutoff_in_a(shutoff_in_a), .shutoff_in_b(shutoff_in_b),
    .torque_off_clear(torque_off_clear), .excite_cmd_in(excite_cmd_in),
    .off_monitor_out(off_monitor_out), .ready_out(ready_out),
    .torque_off_flag_out(torque_off_flag_out), .irq_out(irq_out),
    .drive_cmd_ready_out(drive_cmd_ready_out), .excite_out(excite_out),
    .brake_release_out(brake_release_out),
    .power_alarm_led_out(power_alarm_led_out),
    .gate_upper_en_out(gate_upper_en_out),
    .gate_lower_en_out(gate_lower_en_out));
  sto_safety_model sto_safety_model_i (.clk_sys_in(clk_sys_in),
    .door_open_in(door_open), .pulse_a_in(pulse_a), .stuck_b_in(stuck_b),
    .feedback_in(off_monitor_out), .shutoff_in_a(shutoff_in_a),
    .shutoff_in_b(shutoff_in_b));
  // verdict and end of run
  task automatic end_of_test();
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // compare one result
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // hang guard
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    logic l;
    tick(4);
    arst_n_in <= 1'b1;
    tick(1);
    rd(12'h000, q);
    check(q, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    tick(10);
    rd(12'h004, q);
    check(q, 32'h0000_00CF);
    wr(12'h00C, 32'h0000_0007);
    tick(2);
    check({31'h0, irq_out}, 32'h1);
    rd(12'h008, q);
    check({31'h0, q[1]}, 32'h1);
    rd(12'h008, q);
    check(q, 32'h0);
    excite_cmd_in <= 1'b1;
    torque_off_clear <= 1'b1;
    tick(4);
    torque_off_clear <= 1'b0;
    tick(6);
    check({excite_out, ready_out, drive_cmd_ready_out, brake_release_out,
           torque_off_flag_out, power_alarm_led_out, gate_upper_en_out,
           gate_lower_en_out}, 32'hF7);
    pulse_a <= 1'b1;
    tick(M);
    pulse_a <= 1'b0;
    tick(10);
    check({excite_out, off_monitor_out, gate_upper_en_out}, 32'h5);
    stuck_b <= 1'b1;
    tick(M + 10);
    check({off_monitor_out, gate_upper_en_out, gate_lower_en_out,
           excite_out}, 32'h0);
    stuck_b <= 1'b0;
    tick(10);
    rd(12'h008, q);
    check({31'h0, q[2]}, 32'h1);
    door_open <= 1'b1;
    tick(15 * M + 1);
    check({off_monitor_out, torque_off_flag_out, ready_out, brake_release_out,
           drive_cmd_ready_out, excite_out, gate_upper_en_out,
           gate_lower_en_out}, 32'hC0);
    check({31'h0, irq_out}, 32'h1);
    l = power_alarm_led_out;
    tick(8);
    check({31'h0, power_alarm_led_out}, {31'h0, ~l});
    wr(12'h000, 32'h0000_0202);
    wr(12'h000, 32'h0000_0203);
    rd(12'h000, q);
    check(q, 32'h0000_0202);
    torque_off_clear <= 1'b1;
    stuck_b <= 1'b1;
    door_open <= 1'b0;
    tick(2 * M);
    rd(12'h004, q);
    check({q[7:6], off_monitor_out}, 32'h2);
    stuck_b <= 1'b0;
    tick(M);
    check({31'h0, excite_out}, 32'h0);
    tick(2 * M + 10);
    check({31'h0, excite_out}, 32'h1);
    end_of_test();
  end
endmodule
bind sto_sequencer sto_asserts #(.FILTER_CYC(FILTER_CYC),
  .CYC_PER_MS(CYC_PER_MS)) sto_asserts_i (.clk_sys_in(clk_sys_in),
  .arst_n_in(arst_n_in), .shutoff_in_a(shutoff_in_a),
  .shutoff_in_b(shutoff_in_b), .excite_cmd_in(excite_cmd_in),
  .off_monitor_out(off_monitor_out), .ready_out(ready_out),
  .torque_off_flag_out(torque_off_flag_out), .excite_out(excite_out),
  .drive_cmd_ready_out(drive_cmd_ready_out),
  .brake_release_out(brake_release_out),
  .power_alarm_led_out(power_alarm_led_out),
  .gate_upper_en_out(gate_upper_en_out),
  .gate_lower_en_out(gate_lower_en_out));
